// file: rtl/awc_defs.vh
// Register offsets, field positions, reset values and encodings of the window comparator.
`ifndef AWC_DEFS_VH
`define AWC_DEFS_VH

`define AWC_CHANNELS 8
`define AWC_DATA_W 12
`define AWC_ADDR_W 8

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define AWC_OFF_CTRL 8'h00
`define AWC_OFF_ALARM_MASK 8'h04
`define AWC_OFF_FLAG_SUMMARY 8'h08
`define AWC_OFF_HIGH_FLAG 8'h0C
`define AWC_OFF_LOW_FLAG 8'h10
`define AWC_OFF_IRQ_STATUS 8'h14
`define AWC_OFF_IRQ_CLEAR 8'h18
`define AWC_OFF_IRQ_ENABLE 8'h1C
`define AWC_PAGE_LIMIT 3'h1
`define AWC_PAGE_CFG 3'h2
`define AWC_PAGE_COUNTER 3'h3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AWC_CTRL_REGION_BIT 0
`define AWC_UPPER_LSB 0
`define AWC_UPPER_MSB 11
`define AWC_LOWER_LSB 16
`define AWC_LOWER_MSB 27
`define AWC_COUNT_LSB 0
`define AWC_COUNT_MSB 3
`define AWC_MARGIN_LSB 4
`define AWC_MARGIN_MSB 7
`define AWC_MARGIN_SHIFT 3

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define AWC_RST_UPPER 12'hFFF
`define AWC_RST_LOWER 12'h000
`define AWC_RST_COUNT 4'h0
`define AWC_RST_MARGIN 4'h0
`define AWC_RST_MASK 8'h00
`define AWC_REGION_OUTSIDE 1'b0
`define AWC_REGION_INSIDE 1'b1

`endif

// file: rtl/awc_channel.v
// One channel of the window comparator: violation test, hysteresis and consecutive counter.
`include "awc_defs.vh"

module awc_channel (
    // Clock, reset and enable
    input wire clock,
    input wire nrst,
    input wire ce,
    // New result for this channel
    input wire sample,
    input wire [11:0] data,
    // Settings
    input wire region,
    input wire [11:0] upperLimit,
    input wire [11:0] lowerLimit,
    input wire [3:0] violationCount,
    input wire [3:0] bandMargin,
    // Results
    output reg setHigh,
    output reg setLow,
    output reg [3:0] runCount
);

    // ----------------------------------------------------------------
    // Comparison
    // ----------------------------------------------------------------
    // Thirteen bits keep margin arithmetic free of wrap-around at the scale ends.
    wire [12:0] value = {1'b0, data};
    wire [12:0] upper = {1'b0, upperLimit};
    wire [12:0] lower = {1'b0, lowerLimit};
    wire [12:0] margin = {6'h00, bandMargin, 3'h0};
    wire aboveUpper = value > upper;
    wire belowLower = value < lower;
    wire insideBand = !aboveUpper && !belowLower;
    wire outsideViol = aboveUpper || belowLower;
    wire violation = (region == `AWC_REGION_INSIDE) ? insideBand : outsideViol;
    // Return test: back in the band by at least the margin (inside mode: out by the margin).
    wire backOutside = (value + margin <= upper) && (value >= lower + margin);
    wire backInside = (value > upper + margin) || (value + margin < lower);
    wire returned = (region == `AWC_REGION_INSIDE) ? backInside : backOutside;

    // ----------------------------------------------------------------
    // Consecutive counter
    // ----------------------------------------------------------------
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            runCount <= 4'h0;
            setHigh <= 1'b0;
            setLow <= 1'b0;
        end else if (ce) begin
            setHigh <= 1'b0;
            setLow <= 1'b0;
            if (sample) begin
                if (violation) begin
                    if (runCount == violationCount) begin
                        runCount <= 4'h0;
                        if (region == `AWC_REGION_INSIDE) begin
                            setHigh <= 1'b1;
                            setLow <= 1'b1;
                        end else begin
                            setHigh <= aboveUpper;
                            setLow <= belowLower;
                        end
                    end else begin
                        runCount <= runCount + 4'h1;
                    end
                end else if (returned) begin
                    runCount <= 4'h0;
                end
            end
        end
    end

endmodule // awc_channel

// file: rtl/awc_window_top.v
// Eight-channel digital window comparator with flags, alarm pin and APB registers.
`include "awc_defs.vh"

module awc_window_top (
    // Clock, reset and enable
    input wire clock,
    input wire nrst,
    input wire ce,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Conversion results
    input wire resultValid,
    input wire [2:0] resultChannel,
    input wire [11:0] resultData,
    // Open-drain alarm pin, active low
    output wire alarmN,
    output wire alarmNOe,
    // Interrupt
    output wire irq
);

    // ----------------------------------------------------------------
    // Settings and state
    // ----------------------------------------------------------------
    reg detectRegionSelect;
    reg [7:0] alarmChannelMask;
    reg [7:0] highFlag;
    reg [7:0] lowFlag;
    reg [7:0] irqStatus;
    reg [7:0] irqEnable;
    reg [11:0] upperLimitPerChannel [0:7];
    reg [11:0] lowerLimitPerChannel [0:7];
    reg [3:0] consecutiveViolationCount [0:7];
    reg [3:0] bandMarginSetting [0:7];
    wire [7:0] setHigh;
    wire [7:0] setLow;
    wire [31:0] runCounts;
    wire [7:0] flagSummary;
    wire [7:0] next_highFlag;
    wire [7:0] next_lowFlag;
    wire [7:0] next_irqStatus;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    // The slave never inserts wait states; read data is captured in the setup cycle.
    wire setupPhase = psel && !penable;
    wire accessPhase = psel && penable;
    wire writeAccess = accessPhase && pwrite && ce;
    wire [2:0] page = paddr[7:5];
    wire [2:0] slot = paddr[4:2];
    wire lowAligned = (paddr[1:0] == 2'b00);
    reg mapped;
    reg [31:0] readValue;

    assign pready = 1'b1;
    assign pslverr = accessPhase && !mapped;

    always @* begin
        mapped = lowAligned;
        readValue = 32'h0000_0000;
        case (page)
            3'h0: begin
                case (paddr)
                    `AWC_OFF_CTRL: readValue = {31'h0000_0000, detectRegionSelect};
                    `AWC_OFF_ALARM_MASK: readValue = {24'h00_0000, alarmChannelMask};
                    `AWC_OFF_FLAG_SUMMARY: readValue = {24'h00_0000, flagSummary};
                    `AWC_OFF_HIGH_FLAG: readValue = {24'h00_0000, highFlag};
                    `AWC_OFF_LOW_FLAG: readValue = {24'h00_0000, lowFlag};
                    `AWC_OFF_IRQ_STATUS: readValue = {24'h00_0000, irqStatus};
                    `AWC_OFF_IRQ_CLEAR: readValue = 32'h0000_0000;
                    `AWC_OFF_IRQ_ENABLE: readValue = {24'h00_0000, irqEnable};
                    default: mapped = 1'b0;
                endcase
            end
            `AWC_PAGE_LIMIT: begin
                readValue = {4'h0, lowerLimitPerChannel[slot], 4'h0, upperLimitPerChannel[slot]};
            end
            `AWC_PAGE_CFG: begin
                readValue = {24'h00_0000, bandMarginSetting[slot],
                    consecutiveViolationCount[slot]};
            end
            `AWC_PAGE_COUNTER: begin
                readValue = {28'h000_0000, runCounts[slot * 4 +: 4]};
            end
            default: mapped = 1'b0;
        endcase
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (ce && setupPhase) begin
            prdata <= (!pwrite && mapped) ? readValue : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Global settings
    // ----------------------------------------------------------------
    wire wrCtrl = writeAccess && (paddr == `AWC_OFF_CTRL);
    wire wrMask = writeAccess && (paddr == `AWC_OFF_ALARM_MASK);
    wire wrHighFlag = writeAccess && (paddr == `AWC_OFF_HIGH_FLAG);
    wire wrLowFlag = writeAccess && (paddr == `AWC_OFF_LOW_FLAG);
    wire wrIrqClear = writeAccess && (paddr == `AWC_OFF_IRQ_CLEAR);
    wire wrIrqEnable = writeAccess && (paddr == `AWC_OFF_IRQ_ENABLE);

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            detectRegionSelect <= `AWC_REGION_OUTSIDE;
            alarmChannelMask <= `AWC_RST_MASK;
            irqEnable <= 8'h00;
        end else if (ce) begin
            if (wrCtrl) begin
                detectRegionSelect <= pwdata[`AWC_CTRL_REGION_BIT];
            end
            if (wrMask) begin
                alarmChannelMask <= pwdata[7:0];
            end
            if (wrIrqEnable) begin
                irqEnable <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Per-channel settings and comparators
    // ----------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < `AWC_CHANNELS; ch = ch + 1) begin : gChan
            wire wrLimit = writeAccess && (page == `AWC_PAGE_LIMIT) && lowAligned
                && (slot == ch);
            wire wrCfg = writeAccess && (page == `AWC_PAGE_CFG) && lowAligned
                && (slot == ch);
            wire sample = ce && resultValid && (resultChannel == ch);

            always @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    upperLimitPerChannel[ch] <= `AWC_RST_UPPER;
                    lowerLimitPerChannel[ch] <= `AWC_RST_LOWER;
                    consecutiveViolationCount[ch] <= `AWC_RST_COUNT;
                    bandMarginSetting[ch] <= `AWC_RST_MARGIN;
                end else if (ce) begin
                    if (wrLimit) begin
                        upperLimitPerChannel[ch] <= pwdata[`AWC_UPPER_MSB:`AWC_UPPER_LSB];
                        lowerLimitPerChannel[ch] <= pwdata[`AWC_LOWER_MSB:`AWC_LOWER_LSB];
                    end
                    if (wrCfg) begin
                        consecutiveViolationCount[ch] <= pwdata[`AWC_COUNT_MSB:`AWC_COUNT_LSB];
                        bandMarginSetting[ch] <= pwdata[`AWC_MARGIN_MSB:`AWC_MARGIN_LSB];
                    end
                end
            end

            awc_channel uChannel (
                .clock(clock),
                .nrst(nrst),
                .ce(ce),
                .sample(sample),
                .data(resultData),
                .region(detectRegionSelect),
                .upperLimit(upperLimitPerChannel[ch]),
                .lowerLimit(lowerLimitPerChannel[ch]),
                .violationCount(consecutiveViolationCount[ch]),
                .bandMargin(bandMarginSetting[ch]),
                .setHigh(setHigh[ch]),
                .setLow(setLow[ch]),
                .runCount(runCounts[ch * 4 +: 4])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Flags and interrupt
    // ----------------------------------------------------------------
    // A flag being set in the same cycle as its clear survives the clear.
    assign next_highFlag = (highFlag & ~(wrHighFlag ? pwdata[7:0] : 8'h00)) | setHigh;
    assign next_lowFlag = (lowFlag & ~(wrLowFlag ? pwdata[7:0] : 8'h00)) | setLow;
    assign next_irqStatus = (irqStatus & ~(wrIrqClear ? pwdata[7:0] : 8'h00))
        | setHigh | setLow;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            highFlag <= 8'h00;
            lowFlag <= 8'h00;
            irqStatus <= 8'h00;
        end else if (ce) begin
            highFlag <= next_highFlag;
            lowFlag <= next_lowFlag;
            irqStatus <= next_irqStatus;
        end
    end

    assign flagSummary = highFlag | lowFlag;
    assign irq = |(irqStatus & irqEnable);

    // ----------------------------------------------------------------
    // Alarm pin
    // ----------------------------------------------------------------
    // The pin is only ever pulled low; an external pull-up gives the idle high level.
    assign alarmN = 1'b0;
    assign alarmNOe = |(flagSummary & alarmChannelMask);

endmodule // awc_window_top

// file: verification/awc_window_sva.sv
// Port-level checks of the window comparator.
module awc_window_sva (
    // Clock, reset and enable
    input wire clock,
    input wire nrst,
    input wire ce,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Results
    input wire resultValid,
    input wire [2:0] resultChannel,
    input wire [11:0] resultData,
    // Alarm and interrupt
    input wire alarmN,
    input wire alarmNOe,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ns;
    wire acc = psel & penable;
    wire wrAcc = acc & pwrite & ce;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    a_ready_high: assert property (pready) else $error("pready low");
    a_alarm_drive: assert property (!alarmN) else $error("alarm data not low");
    a_err_align: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access without error");
    a_err_idle: assert property (!acc |-> !pslverr) else $error("error outside access");
    a_err_read: assert property (psel && !penable && ce && paddr == 8'h80 |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    // Flags land two sampled edges after the result, so a rise after neither a result nor a register write is spurious.
    a_irq_rise: assert property ($rose(irq) |-> $past(resultValid, 2) || $past(wrAcc))
        else $error("irq rose without cause");
    a_alarm_rise: assert property ($rose(alarmNOe) |-> $past(resultValid, 2) || $past(wrAcc))
        else $error("alarm rose without cause");
    a_irq_fall: assert property ($fell(irq) |-> $past(wrAcc))
        else $error("irq fell without a write");
    a_irq_clear: assert property (wrAcc && paddr == 8'h18 && pwdata[7:0] == 8'hFF
        && !$past(resultValid) |=> !irq) else $error("irq clear ignored");
    a_ce_hold: assert property (!ce |=> $stable(irq) && $stable(alarmNOe))
        else $error("state moved with ce low");
    c_irq: cover property ($rose(irq));
    c_alarm: cover property ($rose(alarmNOe));
    c_err: cover property (acc && pslverr);
endmodule // awc_window_sva

// file: verification/awc_host.sv
// APB host model that reaches the comparator registers.
module awc_host (
    // Clock
    input wire clock,
    // APB request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // APB answer
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // No cycle count is assumed; a hung slave is caught by the bench timeout.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] r, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // awc_host

// file: verification/tb.sv
// Self-checking bench of the window comparator.
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, nrst, ce, resultValid, rerr;
    logic [2:0] resultChannel;
    logic [11:0] resultData;
    logic [31:0] rdata;
    wire psel, penable, pwrite, pready, pslverr, alarmN, alarmNOe, irq;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    wire alarmLine = alarmNOe ? alarmN : 1'b1;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    awc_window_top DUT (.clock(clock), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .resultValid(resultValid), .resultChannel(resultChannel),
        .resultData(resultData), .alarmN(alarmN), .alarmNOe(alarmNOe), .irq(irq));
    awc_host host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            end_sim();
        end
    end
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rdata, rerr);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, rdata, rerr);
        `CHK(rdata, e)
    endtask
    task res(input logic [2:0] c, input logic [11:0] v);
        @(posedge clock);
        resultValid <= 1'b1;
        resultChannel <= c;
        resultData <= v;
        @(posedge clock);
        resultValid <= 1'b0;
    endtask
    task t_outside;
        static logic [11:0] seqA [6] = '{12'h900, 12'h900, 12'h700, 12'h900, 12'h900, 12'h7FC};
        wr(8'h20, 32'h0100_0800);
        wr(8'h40, 32'h0000_0012);
        wr(8'h04, 32'h0000_0001);
        wr(8'h1C, 32'h0000_00FF);
        foreach (seqA[i]) res(3'h0, seqA[i]);
        rc(8'h0C, 32'h0);
        rc(8'h60, 32'h2);
        res(3'h0, 12'h900);
        rc(8'h0C, 32'h1);
        rc(8'h10, 32'h0);
        rc(8'h08, 32'h1);
        @(negedge clock);
        `CHK(alarmLine, 1'b0)
        `CHK(irq, 1'b1)
        $display("test outside done");
    endtask
    task t_clear;
        wr(8'h0C, 32'h0);
        rc(8'h0C, 32'h1);
        wr(8'h0C, 32'h1);
        rc(8'h0C, 32'h0);
        rc(8'h08, 32'h0);
        @(negedge clock);
        `CHK(alarmLine, 1'b1)
        wr(8'h18, 32'hFF);
        @(negedge clock);
        `CHK(irq, 1'b0)
        $display("test clear done");
    endtask
    task t_mask;
        wr(8'h24, 32'h0200_0FFF);
        res(3'h1, 12'h010);
        rc(8'h10, 32'h2);
        rc(8'h0C, 32'h0);
        @(negedge clock);
        `CHK(alarmLine, 1'b1)
        wr(8'h04, 32'h3);
        @(negedge clock);
        `CHK(alarmLine, 1'b0)
        wr(8'h10, 32'h2);
        wr(8'h18, 32'hFF);
        $display("test mask done");
    endtask
    task t_inside;
        wr(8'h00, 32'h1);
        res(3'h2, 12'h500);
        rc(8'h0C, 32'h4);
        rc(8'h10, 32'h4);
        rc(8'h14, 32'h4);
        @(negedge clock);
        `CHK(irq, 1'b1)
        wr(8'h1C, 32'hFB);
        @(negedge clock);
        `CHK(irq, 1'b0)
        wr(8'h00, 32'h0);
        $display("test inside done");
    endtask
    task t_regs;
        rc(8'h2C, 32'h0000_0FFF);
        wr(8'h4C, 32'hFFFF_FFFF);
        rc(8'h4C, 32'h0000_00FF);
        rc(8'h80, 32'h0);
        `CHK(rerr, 1'b1)
        rc(8'h82, 32'h0);
        `CHK(rerr, 1'b1)
        @(posedge clock);
        ce <= 1'b0;
        res(3'h0, 12'h900);
        @(posedge clock);
        ce <= 1'b1;
        rc(8'h60, 32'h0);
        $display("test regs done");
    endtask
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        resultValid = 1'b0;
        resultChannel = 3'h0;
        resultData = 12'h000;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        t_outside();
        t_clear();
        t_mask();
        t_inside();
        t_regs();
        end_sim();
    end
endmodule // tb
bind awc_window_top awc_window_sva chk (.clock(clock), .nrst(nrst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .resultValid(resultValid),
    .resultChannel(resultChannel), .resultData(resultData), .alarmN(alarmN),
    .alarmNOe(alarmNOe), .irq(irq));
